/* File: design/ercc_run_control.sv */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ercc_params.svh"

module ercc_run_control (
  input  wire logic                  sys_clk,      // 250 MHz clock
  input  wire logic                  resetn,       // Async reset, low
  input  wire logic                  clk_en,       // Freezes state when low
  input  wire ercc_pkg::ercc_bus_s   bus,          // Register request
  output logic [15:0]                rdata,        // Read data, next cycle
  input  wire ercc_pkg::ercc_events_s events,      // Event pulses
  input  wire logic                  suspend_flag, // Suspend level
  input  wire logic                  fetch_done,   // Init fetch finished
  input  wire logic                  frame_start,  // Next frame found
  output logic                       fetch_start,  // Init fetch pulse
  output logic                       tx_enable,    // Transmitter on
  output logic                       rx_enable,    // Receiver on
  output logic                       active,       // External activity ok
  output logic [23:0]                init_block_address, // Shadow address
  output logic                       irq           // Interrupt request
);
  import ercc_pkg::*;

  logic        halt;
  logic        run_request;
  logic        init_bit;
  logic        transmit_demand;
  logic        interrupt_enable_bit;
  logic [15:0] init_block_address_low;
  logic [7:0]  init_block_address_high;
  logic [15:0] init_addr_low_shadow;
  logic [7:0]  init_addr_high_shadow;
  logic [15:0] masks;
  logic [15:0] flags;
  logic [7:0]  fetch_cnt;
  logic        tx_on;
  logic        rx_on;
  logic        uflo_wait;
  // Sticky until the sequencer leaves running or a later underflow arrives with mask bit ERCC_BIT_UFLO_DIS set.
  logic        uflo_stop;
  ercc_state_e state;
  logic        halt_req;
  logic        run_req;
  logic        init_req;
  logic        addr_open;
  logic        interrupt_summary_flag;
  logic        fetch_finished;

  function automatic logic wbit(input ercc_bus_s b, input logic [3:0] a,
                                input int n);
    wbit = b.wr && (b.addr == a) && b.wdata[n];
  endfunction

  assign halt_req = wbit(bus, `ERCC_ADDR_RUN_CTRL, `ERCC_BIT_HALT);
  // Halt dominates, so run and initialise are dropped with it.
  assign run_req  = wbit(bus, `ERCC_ADDR_RUN_CTRL, `ERCC_BIT_RUN)
                    && !halt_req;
  assign init_req = wbit(bus, `ERCC_ADDR_RUN_CTRL, `ERCC_BIT_INIT)
                    && !halt_req;
  assign addr_open = halt || suspend_flag;
  assign fetch_finished = (state == ERCC_INIT) &&
                          (fetch_done || fetch_cnt == 8'h01);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      halt <= 1'b1;
    end else if (clk_en) begin
      if (halt_req) begin
        halt <= 1'b1;
      end else if (run_req || init_req) begin
        halt <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_request <= 1'b0;
      init_bit    <= 1'b0;
      interrupt_enable_bit <= 1'b0;
    end else if (clk_en) begin
      if (halt_req) begin
        run_request <= 1'b0;
        init_bit    <= 1'b0;
        interrupt_enable_bit <= 1'b0;
      end else begin
        if (run_req) begin
          run_request <= 1'b1;
        end
        if (init_req) begin
          init_bit <= 1'b1;
        end
        if (bus.wr && bus.addr == `ERCC_ADDR_RUN_CTRL) begin
          interrupt_enable_bit <= bus.wdata[`ERCC_BIT_INTERRUPT_ENABLE_BIT];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_demand <= 1'b0;
    end else if (clk_en) begin
      if (halt_req || !tx_on) begin
        transmit_demand <= 1'b0;
      end else if (wbit(bus, `ERCC_ADDR_RUN_CTRL, `ERCC_BIT_TRANSMIT_DEMAND)) begin
        transmit_demand <= 1'b1;
      end
    end
  end

  // Sequencer: when initialise and run are requested together, initialise completes before running starts.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ERCC_IDLE;
      fetch_cnt <= 8'h00;
    end else if (clk_en) begin
      if (halt_req) begin
        state     <= ERCC_IDLE;
        fetch_cnt <= 8'h00;
      end else begin
        unique case (state)
          ERCC_IDLE: begin
            if (init_req) begin
              state     <= ERCC_INIT;
              fetch_cnt <= `ERCC_INIT_CYCLES;
            end else if (run_req) begin
              state <= ERCC_RUNNING;
            end
          end
          ERCC_INIT: begin
            if (fetch_finished) begin
              fetch_cnt <= 8'h00;
              state <= run_request ? ERCC_RUNNING : ERCC_IDLE;
            end else begin
              fetch_cnt <= fetch_cnt - 8'h01;
            end
          end
          ERCC_RUNNING: begin
            if (init_req) begin
              state     <= ERCC_INIT;
              fetch_cnt <= `ERCC_INIT_CYCLES;
            end
          end
        endcase
      end
    end
  end

  // Transmit and receive enables with underflow handling.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_on     <= 1'b0;
      rx_on     <= 1'b0;
      uflo_wait <= 1'b0;
      uflo_stop <= 1'b0;
    end else if (clk_en) begin
      if (halt_req || state != ERCC_RUNNING) begin
        tx_on     <= 1'b0;
        rx_on     <= 1'b0;
        uflo_wait <= 1'b0;
        uflo_stop <= 1'b0;
      end else if (events.underflow) begin
        tx_on     <= 1'b0;
        uflo_wait <= masks[`ERCC_BIT_UFLO_DIS];
        uflo_stop <= !masks[`ERCC_BIT_UFLO_DIS];
        rx_on     <= 1'b1;
      end else if (uflo_wait) begin
        if (frame_start) begin
          tx_on     <= 1'b1;
          uflo_wait <= 1'b0;
        end
        rx_on <= 1'b1;
      end else begin
        rx_on <= 1'b1;
        if (!tx_on && !uflo_stop && fetch_cnt == 8'h00 && !halt) begin
          tx_on <= 1'b1;
        end
      end
    end
  end

  // Address registers and shadows; reset leaves them alone.
  always_ff @(posedge sys_clk) begin
    if (clk_en && bus.wr && addr_open) begin
      if (bus.addr == `ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW) begin
        init_block_address_low <= bus.wdata & `ERCC_LOW_WMASK;
        init_addr_low_shadow <= bus.wdata & `ERCC_LOW_WMASK;
      end
      if (bus.addr == `ERCC_ADDR_INIT_BLOCK_ADDRESS_HIGH) begin
        init_block_address_high <= bus.wdata[7:0];
        init_addr_high_shadow <= bus.wdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      masks <= `ERCC_RST_MASKS;
    end else if (clk_en && bus.wr && bus.addr == `ERCC_ADDR_MASKS) begin
      masks <= bus.wdata & `ERCC_MASK_WMASK;
    end
  end

  // Event flags: set wins over the write-one clear.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags <= 16'h0000;
    end else if (clk_en) begin
      if (halt_req) begin
        flags <= 16'h0000;
      end else begin
        for (int i = 8; i < 16; i++) begin
          if (bus.wr && bus.addr == `ERCC_ADDR_RUN_CTRL && bus.wdata[i]) begin
            flags[i] <= 1'b0;
          end
        end
        if (events.babble)  flags[`ERCC_BIT_BABBLE_FLAG] <= 1'b1;
        if (events.missed)  flags[`ERCC_BIT_MISS] <= 1'b1;
        if (events.mem_err) flags[`ERCC_BIT_MEMORY_ERROR_FLAG] <= 1'b1;
        if (events.rx_done) flags[`ERCC_BIT_RECEIVE_DONE_FLAG] <= 1'b1;
        if (events.tx_done) flags[`ERCC_BIT_TRANSMIT_DONE_FLAG] <= 1'b1;
        if (fetch_finished) flags[`ERCC_BIT_INIT_DONE_FLAG] <= 1'b1;
      end
    end
  end

  assign interrupt_summary_flag =
    |(flags & ~masks & `ERCC_EVENT_BITS);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= interrupt_enable_bit && interrupt_summary_flag;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_start <= 1'b0;
    end else if (clk_en) begin
      fetch_start <= init_req;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= 16'h0000;
      if (bus.rd) begin
        unique case (bus.addr)
          `ERCC_ADDR_RUN_CTRL: rdata <= {flags[15:8], interrupt_summary_flag,
            interrupt_enable_bit, rx_on, tx_on, transmit_demand, halt,
            run_request, init_bit};
          `ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW: rdata <= addr_open ? init_block_address_low : 16'h0000;
          `ERCC_ADDR_INIT_BLOCK_ADDRESS_HIGH:
            rdata <= addr_open ? {8'h00, init_block_address_high} : 16'h0000;
          `ERCC_ADDR_MASKS:      rdata <= masks;
          `ERCC_ADDR_SHADOW_LOW: rdata <= init_addr_low_shadow;
          `ERCC_ADDR_SHADOW_HI:  rdata <= {8'h00, init_addr_high_shadow};
          default:               rdata <= 16'h0000;
        endcase
      end
    end
  end

  assign tx_enable = tx_on;
  assign rx_enable = rx_on;
  assign active    = !halt;
  assign init_block_address = {init_addr_high_shadow, init_addr_low_shadow};

  AST_HALT_PRIORITY: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && halt_req |=> halt && !run_request && !init_bit)
    else $error("halt did not win");
  AST_RUN_CLEARS_HALT: assert property (@(posedge sys_clk)
    disable iff (!resetn) clk_en && run_req |=> !halt)
    else $error("run did not clear halt");
  AST_HALT_QUIET: assert property (@(posedge sys_clk) disable iff (!resetn)
    halt |-> !tx_enable && !rx_enable && !active)
    else $error("activity while halted");
  AST_TRANSMIT_DEMAND_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && halt_req |=> !transmit_demand)
    else $error("transmit demand survived halt");
  AST_INIT_BEFORE_RUN: assert property (@(posedge sys_clk)
    disable iff (!resetn) clk_en && init_req && run_req && state == ERCC_IDLE
    |=> state == ERCC_INIT)
    else $error("run started before init");
  AST_SHADOW_COPY: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    clk_en && bus.wr && addr_open && bus.addr == `ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW
    |=> init_addr_low_shadow == ($past(bus.wdata) & `ERCC_LOW_WMASK))
    else $error("low shadow not updated");
  AST_ADDR_LOCK: assert property (@(posedge sys_clk) disable iff (!resetn)
    !addr_open |=> $stable(init_addr_low_shadow))
    else $error("address changed while locked");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !interrupt_enable_bit |=> !irq)
    else $error("irq without enable");
  AST_MASK_WIN: assert property (@(posedge sys_clk) disable iff (!resetn)
    flags[`ERCC_BIT_INIT_DONE_FLAG] && !masks[`ERCC_BIT_INIT_DONE_FLAG]
    |-> interrupt_summary_flag)
    else $error("unmasked flag missed summary");
  AST_HIGH_ZERO: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    clk_en && bus.rd && bus.addr == `ERCC_ADDR_INIT_BLOCK_ADDRESS_HIGH
    |=> rdata[15:8] == 8'h00)
    else $error("high byte not zero");
  AST_UFLO_STOP: assert property (@(posedge sys_clk)
    disable iff (!resetn)
    clk_en && state == ERCC_RUNNING && events.underflow
    && !masks[`ERCC_BIT_UFLO_DIS] |=> !tx_enable)
    else $error("transmit kept running after underflow");

  COV_INIT_RUN: cover property (@(posedge sys_clk) disable iff (!resetn)
    state == ERCC_INIT ##1 state == ERCC_RUNNING);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (!resetn) irq);
  COV_UFLO: cover property (@(posedge sys_clk) disable iff (!resetn)
    uflo_wait ##1 tx_on);
endmodule
`default_nettype wire

/* File: design/ercc_params.svh */
`ifndef ERCC_PARAMS_SVH
`define ERCC_PARAMS_SVH

// Register word addresses on the plain register port.
`define ERCC_ADDR_RUN_CTRL   4'h0
`define ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW   4'h1
`define ERCC_ADDR_INIT_BLOCK_ADDRESS_HIGH  4'h2
`define ERCC_ADDR_MASKS      4'h3
`define ERCC_ADDR_SHADOW_LOW 4'h4
`define ERCC_ADDR_SHADOW_HI  4'h5
`define ERCC_ADDR_EVENTS     4'h6

// Run-control register fields.
`define ERCC_BIT_INIT        0
`define ERCC_BIT_RUN         1
`define ERCC_BIT_HALT        2
`define ERCC_BIT_TRANSMIT_DEMAND        3
`define ERCC_BIT_TXON        4
`define ERCC_BIT_RXON        5
`define ERCC_BIT_INTERRUPT_ENABLE_BIT        6
`define ERCC_BIT_INTERRUPT_SUMMARY_FLAG        7
`define ERCC_BIT_INIT_DONE_FLAG        8
`define ERCC_BIT_TRANSMIT_DONE_FLAG        9
`define ERCC_BIT_RECEIVE_DONE_FLAG        10
`define ERCC_BIT_MEMORY_ERROR_FLAG        11
`define ERCC_BIT_MISS        12
`define ERCC_BIT_BABBLE_FLAG        14

// Mask register fields and writable bits.
`define ERCC_BIT_UFLO_DIS    6
`define ERCC_MASK_WMASK      16'h5F7F
`define ERCC_EVENT_BITS      16'h5F00

// Reset value and write masks.
`define ERCC_RST_MASKS       16'h0000
`define ERCC_HIGH_WMASK      16'h00FF
`define ERCC_LOW_WMASK       16'hFFFE

// Initialization fetch length in cycles.
`define ERCC_INIT_CYCLES     8'h10

`endif

/* File: design/ercc_pkg.sv */
package ercc_pkg;
  typedef enum logic [1:0] {
    ERCC_IDLE    = 2'b00,
    ERCC_INIT    = 2'b01,
    ERCC_RUNNING = 2'b10
  } ercc_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } ercc_bus_s;

  typedef struct packed {
    logic babble;
    logic missed;
    logic mem_err;
    logic rx_done;
    logic tx_done;
    logic underflow;
  } ercc_events_s;
endpackage

/* File: dv/ercc_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Memory side of the initialization fetch. A delay of zero never answers,
// which lets the bench exercise the fetch timeout.
module ercc_fetch_model (
  input  wire logic       sys_clk,     // Clock
  input  wire logic       resetn,      // Async reset, low
  input  wire logic       fetch_start, // Fetch request pulse
  input  wire logic [7:0] delay,       // Answer latency, 0 never
  output logic            fetch_done   // Fetch finished pulse
);
  logic [7:0] count;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count      <= 8'h00;
      fetch_done <= 1'b0;
    end else begin
      fetch_done <= (count == 8'h01);
      if (fetch_start) begin
        count <= delay;
      end else if (count != 8'h00) begin
        count <= count - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ercc_params.svh"
module testbench;
  import ercc_pkg::*;
  logic         sys_clk = 1'b0;
  logic         resetn = 1'b0;
  logic         clk_en = 1'b1;
  ercc_bus_s    bus = '0;
  ercc_events_s events = '0;
  logic         suspend_flag = 1'b0;
  logic         frame_start = 1'b0;
  logic [7:0]   fetch_delay = 8'h03;
  logic         fetch_done, fetch_start, tx_enable, rx_enable, active, irq;
  logic [15:0]  rdata;
  logic [23:0]  init_block_address;
  logic         seen_fetch = 1'b0;
  int           num_errors = 0;
  int           check_count = 0;
  int           cycles = 0;
  ercc_run_control dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .bus(bus), .rdata(rdata), .events(events),
    .suspend_flag(suspend_flag), .fetch_done(fetch_done),
    .frame_start(frame_start), .fetch_start(fetch_start),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .active(active),
    .init_block_address(init_block_address), .irq(irq));
  ercc_fetch_model mem_u (.sys_clk(sys_clk), .resetn(resetn),
    .fetch_start(fetch_start), .delay(fetch_delay),
    .fetch_done(fetch_done));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (fetch_start === 1'b1) seen_fetch <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge sys_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk) bus <= '0;
  endtask
  task automatic rd(string what, logic [3:0] a, logic [15:0] exp);
    @(posedge sys_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    @(posedge sys_clk) bus <= '0;
    #1 chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic pulse(ercc_events_s e);
    @(posedge sys_clk) events <= e;
    @(posedge sys_clk) events <= '0;
  endtask
  task automatic t_reset();
    rd("ctrl", `ERCC_ADDR_RUN_CTRL, 16'h0004);
    rd("masks", `ERCC_ADDR_MASKS, 16'h0000);
    chk("active", 24'h0, 24'(active));
    $display("test reset done");
  endtask
  task automatic t_addr();
    wr(`ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW, 16'h1234);
    wr(`ERCC_ADDR_INIT_BLOCK_ADDRESS_HIGH, 16'h0056);
    rd("low", `ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW, 16'h1234);
    rd("high", `ERCC_ADDR_INIT_BLOCK_ADDRESS_HIGH, 16'h0056);
    rd("shlow", `ERCC_ADDR_SHADOW_LOW, 16'h1234);
    rd("shhigh", `ERCC_ADDR_SHADOW_HI, 16'h0056);
    chk("addr", 24'h561234, init_block_address);
    $display("test address done");
  endtask
  task automatic t_halt_prio();
    seen_fetch <= 1'b0;
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0007);
    idle(4);
    rd("ctrl", `ERCC_ADDR_RUN_CTRL, 16'h0004);
    chk("fetch", 24'h0, 24'(seen_fetch));
    chk("active", 24'h0, 24'(active));
    $display("test halt priority done");
  endtask
  task automatic t_init_run();
    seen_fetch <= 1'b0;
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0003);
    idle(2);
    chk("fetch", 24'h1, 24'(seen_fetch));
    chk("tx", 24'h0, 24'({tx_enable, rx_enable}));
    chk("active", 24'h1, 24'(active));
    for (int k = 0; k < 40 && tx_enable !== 1'b1; k++) idle(1);
    chk("txrx", 24'h3, 24'({tx_enable, rx_enable}));
    rd("ctrl", `ERCC_ADDR_RUN_CTRL, 16'h01B3);
    $display("test init run done");
  endtask
  task automatic t_lock();
    wr(`ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW, 16'hAAAA);
    idle(2);
    chk("addr", 24'h561234, init_block_address);
    rd("low", `ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW, 16'h0000);
    @(posedge sys_clk) suspend_flag <= 1'b1;
    wr(`ERCC_ADDR_INIT_BLOCK_ADDRESS_LOW, 16'h2468);
    idle(2);
    chk("addr", 24'h562468, init_block_address);
    @(posedge sys_clk) suspend_flag <= 1'b0;
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0000);
    idle(2);
    rd("ctrl", `ERCC_ADDR_RUN_CTRL, 16'h01B3);
    $display("test lock done");
  endtask
  task automatic t_masks();
    int mbit[5] = '{14, 12, 11, 10, 9};
    int ebit[5] = '{5, 4, 3, 2, 1};
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0040);
    idle(3);
    chk("irq", 24'h1, 24'(irq));
    wr(`ERCC_ADDR_MASKS, 16'h0100);
    idle(3);
    chk("irq", 24'h0, 24'(irq));
    for (int i = 0; i < 5; i++) begin
      wr(`ERCC_ADDR_RUN_CTRL, 16'h7F40);
      wr(`ERCC_ADDR_MASKS, 16'(1 << mbit[i]));
      pulse(ercc_events_s'(1 << ebit[i]));
      idle(3);
      chk("irqmask", 24'h0, 24'(irq));
      wr(`ERCC_ADDR_MASKS, 16'h0000);
      idle(3);
      chk("irqopen", 24'h1, 24'(irq));
    end
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0000);
    idle(3);
    chk("irqoff", 24'h0, 24'(irq));
    wr(`ERCC_ADDR_RUN_CTRL, 16'h7F00);
    $display("test masks done");
  endtask
  task automatic t_underflow();
    wr(`ERCC_ADDR_MASKS, 16'h0040);
    pulse('{underflow: 1'b1, default: 1'b0});
    @(posedge sys_clk) frame_start <= 1'b1;
    @(posedge sys_clk) frame_start <= 1'b0;
    idle(3);
    chk("txresume", 24'h1, 24'(tx_enable));
    wr(`ERCC_ADDR_MASKS, 16'h0A00);
    pulse('{underflow: 1'b1, default: 1'b0});
    idle(3);
    chk("txstop", 24'h0, 24'(tx_enable));
    $display("test underflow done");
  endtask
  task automatic t_halt();
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0008);
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0004);
    idle(2);
    rd("ctrl", `ERCC_ADDR_RUN_CTRL, 16'h0004);
    chk("txrx", 24'h0, 24'({tx_enable, rx_enable, active}));
    rd("masks", `ERCC_ADDR_MASKS, 16'h0A00);
    $display("test halt done");
  endtask
  task automatic t_slow_fetch();
    fetch_delay <= 8'h00;
    wr(`ERCC_ADDR_RUN_CTRL, 16'h0001);
    idle(24);
    rd("ctrl", `ERCC_ADDR_RUN_CTRL, 16'h0181);
    $display("test slow fetch done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_addr();
    t_halt_prio();
    t_init_run();
    t_lock();
    t_masks();
    t_underflow();
    t_halt();
    t_slow_fetch();
    wrap_up();
  end
endmodule
`default_nettype wire
